// *** include/sccr_pkg.sv ***
// Purpose: Shared constants and types for the channel configuration register pair.
// Assumes: Registers are reached through the device's internal register port.
// Notes: Factory one-time-programmable reset values arrive as inputs.
package sccr_pkg;
    localparam logic [7:0] SCCR_CH1_CTRL_ADDR = 8'h2C;
    localparam logic [7:0] SCCR_CH2_VOLT_ADDR = 8'h2D;
    localparam int SCCR_RSVD_BIT = 7;
    localparam int SCCR_TOPO_BIT = 6;
    localparam int SCCR_LIMIT_MSB = 5;
    localparam int SCCR_LIMIT_LSB = 4;
    localparam int SCCR_DISCH_BIT = 3;
    localparam int SCCR_ENSEL_MSB = 2;
    localparam int SCCR_ENSEL_LSB = 0;
    localparam int SCCR_VOLT_MSB = 6;
    localparam logic SCCR_RSVD_RESET = 1'h0;
    localparam logic [6:0] SCCR_VOLT_SAT_CODE = 7'h5E;
    localparam logic [6:0] SCCR_VOLT_MAX_CODE = 7'h5E;
    // Target in 50 mV steps above 0.8 V; base and step given in millivolts, the top given as a code.
    localparam int SCCR_VOLT_BASE_MV = 800;
    localparam int SCCR_VOLT_STEP_MV = 50;

    typedef struct packed {
        logic       topology_select;
        logic [1:0] ch1_peak_limit;
        logic       ch1_discharge_enable;
        logic [2:0] ch1_enable_select;
        logic [6:0] ch2_target_voltage;
    } sccr_otp_type;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sccr_req_type;
endpackage

// *** hdl/sccr_regs.sv ***
// Purpose: Channel one control and channel two voltage registers with decoded outputs.
// Assumes: Register port requests come from logic on the same clock.
// Notes: Read data is registered and valid one cycle after rd_en.
`timescale 1ns/1ps
module sccr_regs
    import sccr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire sccr_otp_type otp,
    input wire sccr_req_type req,
    input wire logic [3:0] seq_slot_active,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic ch1_buck_only,
    output logic [1:0] ch1_limit_sel,
    output logic ch1_enable,
    output logic ch1_discharge_on,
    output logic [6:0] ch2_volt_code,
    output logic [12:0] ch2_target_mv
);
    logic [7:0] ch1_reg;
    logic [7:0] ch1_next;
    logic [6:0] volt_reg;
    logic [6:0] volt_next;
    logic [7:0] rdata_next;
    logic [12:0] mv_next;
    logic en_next;

    wire hit_ch1 = req.addr == SCCR_CH1_CTRL_ADDR;
    wire hit_volt = req.addr == SCCR_CH2_VOLT_ADDR;
    wire [2:0] ensel = ch1_reg[SCCR_ENSEL_MSB:SCCR_ENSEL_LSB];
    wire [6:0] volt_sat = (volt_reg >= SCCR_VOLT_SAT_CODE) ? SCCR_VOLT_MAX_CODE : volt_reg;

    // The reserved bit is stored as zero so a careless write cannot leak into reads.
    assign ch1_next = (req.wr_en && hit_ch1) ? {1'h0, req.wdata[6:0]} : ch1_reg;
    assign volt_next = (req.wr_en && hit_volt) ? req.wdata[6:0] : volt_reg;
    assign rdata_next = hit_ch1 ? ch1_reg : (hit_volt ? {1'h0, volt_reg} : 8'h00);
    // Slot codes follow the sequencer; bit 2 set means forced, bit 0 ignored there.
    assign en_next = ensel[2] ? ensel[1] : seq_slot_active[ensel[1:0]];
    assign mv_next = 13'(SCCR_VOLT_BASE_MV) + 13'(volt_sat) * 13'(SCCR_VOLT_STEP_MV);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ch1_reg <= {SCCR_RSVD_RESET, otp.topology_select, otp.ch1_peak_limit,
                        otp.ch1_discharge_enable, otp.ch1_enable_select};
            volt_reg <= otp.ch2_target_voltage;
            rdata <= 8'h00;
            rvalid <= 1'h0;
        end else begin
            ch1_reg <= ch1_next;
            volt_reg <= volt_next;
            rdata <= req.rd_en ? rdata_next : 8'h00;
            rvalid <= req.rd_en;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ch1_buck_only <= 1'h0;
            ch1_limit_sel <= 2'h0;
            ch1_enable <= 1'h0;
            ch1_discharge_on <= 1'h0;
            ch2_volt_code <= 7'h00;
            ch2_target_mv <= 13'(SCCR_VOLT_BASE_MV);
        end else begin
            ch1_buck_only <= ch1_reg[SCCR_TOPO_BIT];
            ch1_limit_sel <= ch1_reg[SCCR_LIMIT_MSB:SCCR_LIMIT_LSB];
            ch1_enable <= en_next;
            ch1_discharge_on <= ch1_reg[SCCR_DISCH_BIT] && !en_next;
            ch2_volt_code <= volt_sat;
            ch2_target_mv <= mv_next;
        end
    end

    // The request steps that several checks below are built from.
    sequence s_ch1_write;
        req.wr_en && hit_ch1;
    endsequence

    sequence s_volt_write;
        req.wr_en && hit_volt;
    endsequence

    sequence s_ch1_read;
        req.rd_en && hit_ch1 && !req.wr_en;
    endsequence

    sequence s_volt_read;
        req.rd_en && hit_volt && !req.wr_en;
    endsequence

    // Register port behaviour: storage, hold and read timing.
    a_rsvd_zero: assert property (@(posedge clk) disable iff (!rstn)
        req.rd_en && hit_ch1 |=> !rdata[SCCR_RSVD_BIT])
        else $error("reserved bit read as one");

    a_ch1_store: assert property (@(posedge clk) disable iff (!rstn)
        s_ch1_write |=> ch1_reg == {1'h0, $past(req.wdata[6:0])})
        else $error("channel one write not stored");

    a_ch1_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(req.wr_en && hit_ch1) |=> $stable(ch1_reg))
        else $error("channel one changed without write");

    a_volt_store: assert property (@(posedge clk) disable iff (!rstn)
        s_volt_write |=> volt_reg == $past(req.wdata[6:0]))
        else $error("voltage write not stored");

    a_volt_hold: assert property (@(posedge clk) disable iff (!rstn)
        !(req.wr_en && hit_volt) |=> $stable(volt_reg))
        else $error("voltage changed without write");

    // A read in the same cycle as a write must still show the old contents.
    a_ch1_read: assert property (@(posedge clk) disable iff (!rstn)
        req.rd_en && hit_ch1 |=> rdata == $past(ch1_reg))
        else $error("channel one read wrong");

    a_volt_read: assert property (@(posedge clk) disable iff (!rstn)
        req.rd_en && hit_volt |=> rdata == {1'h0, $past(volt_reg)})
        else $error("voltage read wrong");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        req.rd_en && !hit_ch1 && !hit_volt |=> rvalid && rdata == 8'h00)
        else $error("unmapped read not zero");

    a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rstn)
        req.rd_en |=> rvalid)
        else $error("read answer missing");

    a_rvalid_idle: assert property (@(posedge clk) disable iff (!rstn)
        !req.rd_en |=> !rvalid && rdata == 8'h00)
        else $error("read answer without request");

    a_read_back: assert property (@(posedge clk) disable iff (!rstn)
        s_volt_write ##1 s_volt_read |=> rdata[6:0] == $past(req.wdata[6:0], 2))
        else $error("read back wrong");

    a_ch1_back: assert property (@(posedge clk) disable iff (!rstn)
        s_ch1_write ##1 s_ch1_read |=> rdata == {1'h0, $past(req.wdata[6:0], 2)})
        else $error("channel one read back wrong");

    // Decoded outputs trail the register by one clock, so a write shows two edges later.
    a_topo_follow: assert property (@(posedge clk) disable iff (!rstn)
        s_ch1_write |=> ##1 ch1_buck_only == $past(req.wdata[SCCR_TOPO_BIT], 2))
        else $error("topology output wrong");

    a_limit_follow: assert property (@(posedge clk) disable iff (!rstn)
        s_ch1_write |=> ##1 ch1_limit_sel == $past(req.wdata[5:4], 2))
        else $error("limit output wrong");

    // Discharge may only act while the channel is off.
    a_disch_on: assert property (@(posedge clk) disable iff (!rstn)
        ch1_reg[SCCR_DISCH_BIT] && !en_next |=> ch1_discharge_on)
        else $error("discharge missing");

    a_disch_off: assert property (@(posedge clk) disable iff (!rstn)
        !ch1_reg[SCCR_DISCH_BIT] |=> !ch1_discharge_on)
        else $error("discharge applied");

    a_disch_forced: assert property (@(posedge clk) disable iff (!rstn)
        ch1_reg[SCCR_DISCH_BIT] && ensel[2:1] == 2'h2 |=> ch1_discharge_on)
        else $error("discharge missing when forced off");

    a_disch_excl: assert property (@(posedge clk) disable iff (!rstn)
        ch1_discharge_on |-> !ch1_enable)
        else $error("discharge while channel on");

    // Enable source selection.
    a_slot_follow: assert property (@(posedge clk) disable iff (!rstn)
        !ensel[2] |=> ch1_enable == $past(seq_slot_active[ensel[1:0]]))
        else $error("slot enable wrong");

    a_force_off: assert property (@(posedge clk) disable iff (!rstn)
        ensel[2:1] == 2'h2 |=> !ch1_enable)
        else $error("forced off failed");

    a_force_on: assert property (@(posedge clk) disable iff (!rstn)
        ensel[2:1] == 2'h3 |=> ch1_enable)
        else $error("forced on failed");

    // Channel two voltage map, linear part and the saturated top.
    a_volt_lin: assert property (@(posedge clk) disable iff (!rstn)
        volt_reg < SCCR_VOLT_SAT_CODE |=> ch2_target_mv ==
        13'(SCCR_VOLT_BASE_MV + SCCR_VOLT_STEP_MV * int'($past(volt_reg))))
        else $error("voltage map wrong");

    a_code_lin: assert property (@(posedge clk) disable iff (!rstn)
        volt_reg < SCCR_VOLT_SAT_CODE |=> ch2_volt_code == $past(volt_reg))
        else $error("voltage code wrong");

    a_volt_sat: assert property (@(posedge clk) disable iff (!rstn)
        volt_reg >= SCCR_VOLT_SAT_CODE |=> ch2_target_mv == 13'h157C)
        else $error("no saturation");

    a_code_sat: assert property (@(posedge clk) disable iff (!rstn)
        volt_reg >= SCCR_VOLT_SAT_CODE |=> ch2_volt_code == SCCR_VOLT_MAX_CODE)
        else $error("code not saturated");

    // The target must never exceed the top of the range, whatever was written.
    a_mv_ceiling: assert property (@(posedge clk) disable iff (!rstn)
        ch2_target_mv <= 13'h157C)
        else $error("target above ceiling");
endmodule

// *** sim/sccr_host.sv ***
// Purpose: Host model issuing single-byte register requests.
// Assumes: The bench pulses go for one cycle, or for two cycles in the back-to-back write then read.
// Notes: Bit 7 of channel one control is always sent as zero.
`timescale 1ns/1ps
module sccr_host
    import sccr_pkg::*;
(
    input wire logic go,
    input wire logic wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output sccr_req_type req
);
    // Bias power mode lives outside this block; the host is trusted to order it.
    wire logic ch1_hit = addr == SCCR_CH1_CTRL_ADDR;
    assign req = '{go & wr, go & ~wr, addr, {wdata[7] & ~ch1_hit, wdata[6:0]}};
endmodule

// *** sim/sccr_regs_tb_top.sv ***
// Purpose: Random register traffic checked against a bench model.
// Assumes: Read answers come within three cycles.
// Notes: Decoded outputs are checked three cycles after any change.
`timescale 1ns/1ps
module sccr_regs_tb_top
    import sccr_pkg::*;
;
    logic clk = 0, rstn = 0, go = 0, wr = 0, rvalid, buck, en, dis, eo;
    logic [7:0] a = 8'h00, d = 8'h00, rdata, m1, m2, c;
    logic [3:0] slot = 4'h0;
    logic [1:0] lim;
    logic [6:0] code;
    logic [12:0] mv;
    sccr_otp_type otp = '0;
    sccr_req_type req;
    int fail_count = 0, checks_done = 0, cyc = 0;
    sccr_host host (.go(go), .wr(wr), .addr(a), .wdata(d), .req(req));
    sccr_regs DUT (.clk(clk), .rstn(rstn), .otp(otp), .req(req), .seq_slot_active(slot),
        .rdata(rdata), .rvalid(rvalid), .ch1_buck_only(buck), .ch1_limit_sel(lim),
        .ch1_enable(en), .ch1_discharge_on(dis), .ch2_volt_code(code), .ch2_target_mv(mv));
    initial forever #12.5 clk = ~clk;
    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic op(input logic w);
        @(negedge clk);
        go = 1'b1;
        wr = w;
        @(negedge clk);
        go = 1'b0;
        for (int i = 0; i < 3 && !w && rvalid !== 1'b1; i++) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] x, input logic [7:0] y);
        a = x;
        op(1'b0);
        chk({7'h00, rvalid, rdata}, {8'h01, y});
    endtask
    task automatic dec();
        repeat (3) @(negedge clk);
        eo = m1[2:0] < 4 ? slot[m1[1:0]] : m1[1];
        c = m2 > 8'h5E ? 8'h5E : m2;
        chk(en, eo);
        chk(dis, m1[3] & ~eo);
        chk({buck, lim}, m1[6:4]);
        chk(code, c);
        chk(mv, 16'(800 + 50 * c));
        rd(8'h2C, m1);
        rd(8'h2D, m2);
        rd(8'h2E, 8'h00);
    endtask
    initial begin
        void'($urandom(32'hB1F2));
        otp = 14'($urandom);
        m1 = {1'b0, otp[13:7]};
        m2 = {1'b0, otp[6:0]};
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        dec();
        $display("Test reset values done");
        for (int i = 0; i < 80; i++) begin
            slot = 4'($urandom);
            a = 8'h2C + 8'($urandom % 3);
            d = 8'($urandom);
            op(1'b1);
            if (a == 8'h2C) m1 = {1'b0, d[6:0]};
            if (a == 8'h2D) m2 = {1'b0, d[6:0]};
            dec();
        end
        $display("Test random writes done");
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            a = (i == 1) ? 8'h2C : 8'h2D;
            d = 8'($urandom);
            go = 1'b1;
            wr = 1'b1;
            @(negedge clk);
            wr = 1'b0;
            @(negedge clk);
            go = 1'b0;
            chk({7'h00, rvalid, rdata}, {8'h01, 1'b0, d[6:0]});
            if (i == 1) m1 = {1'b0, d[6:0]};
            else m2 = {1'b0, d[6:0]};
        end
        dec();
        $display("Test back-to-back done");
        results();
    end
endmodule
